// [logic/irq_test_pkg.sv]
package irq_test_pkg;

  // register port shape: bit 16 selects the page, bits 15:0 are the byte offset
  localparam int ADDR_W   = 17;
  localparam int OFFS_W   = 16;
  localparam int PAGE_BIT = 16;
  localparam int WORD_W   = 32;

  // distributor test page
  localparam logic [15:0] OFF_ERR_TEST         = 16'hC004;
  localparam logic [15:0] OFF_EVENT_STATUS     = 16'hC010;
  localparam logic [15:0] OFF_EVENT_MASK       = 16'hC014;
  localparam logic [15:0] OFF_SPI_STATUS_FIRST = 16'hC084;
  localparam logic [15:0] OFF_SPI_STATUS_LAST  = 16'hC0F8;

  // redistributor test page
  localparam logic [15:0] OFF_MISC_STATUS = 16'hC000;
  localparam logic [15:0] OFF_PRIV_STATUS = 16'hC080;

  // error test fields
  localparam int ERR_ECC_BIT  = 0;
  localparam int ERR_BUSM_BIT = 1;

  // shared interrupt wires
  localparam int MAX_SPI      = 960;
  localparam int SPI_BASE_ID  = 32;
  localparam int SPI_IDX_W    = 5;

  // event status / mask layout
  localparam int EVT_W        = 3;
  localparam int EVT_ECC_BIT  = 0;
  localparam int EVT_BUSM_BIT = 1;
  localparam int EVT_SPI_BIT  = 2;
  localparam logic [EVT_W-1:0] EVT_STATUS_RST = 3'h0;
  localparam logic [EVT_W-1:0] EVT_MASK_RST   = 3'h0;

  // miscellaneous status layout
  localparam int MISC_ACTIVE_BIT = 31;
  localparam int MISC_G1S_BIT    = 2;
  localparam int MISC_G1NS_BIT   = 1;
  localparam int MISC_G0_BIT     = 0;

  // private interrupt wires sit at their interrupt number
  localparam int PPI_W         = 16;
  localparam int PPI_FIRST_BIT = 16;

  localparam logic [WORD_W-1:0] RDATA_RST = 32'h0000_0000;

  function automatic logic [SPI_IDX_W-1:0] spi_reg_index(input logic [OFFS_W-1:0] off);
    logic [OFFS_W-1:0] delta;
    delta = off - OFF_SPI_STATUS_FIRST;
    return delta[SPI_IDX_W+1:2];
  endfunction : spi_reg_index

endpackage : irq_test_pkg

// [logic/pin_level_filter.sv]
`timescale 1ns/1ps
`default_nettype none
module pin_level_filter
  import irq_test_pkg::*;
#(
  parameter int W = 1
)
(
  // clock and reset
  input  wire logic         clock_in,
  input  wire logic         rstn_in,
  // pins and filtered levels
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level_out
);

  if (W < 1)
  begin : g_bad_width
    $error("pin_level_filter needs at least one pin");
  end

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;
  logic [W-1:0] next_level;

  // a level change only counts once the second and third stage agree
  always_comb
  begin
    next_level = (~(stage2 ^ stage3) & stage3) | ((stage2 ^ stage3) & level_out);
  end

  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      stage1    <= '0;
      stage2    <= '0;
      stage3    <= '0;
      level_out <= '0;
    end
    else
    begin
      stage1    <= pin_in;
      stage2    <= stage1;
      stage3    <= stage2;
      level_out <= next_level;
    end
  end

endmodule : pin_level_filter
`default_nettype wire

// [logic/spi_word_select.sv]
`timescale 1ns/1ps
`default_nettype none
module spi_word_select
  import irq_test_pkg::*;
#(
  parameter int NUM_SPI = 960
)
(
  // filtered wire levels and group membership
  input  wire logic [NUM_SPI-1:0]   level_in,
  input  wire logic [NUM_SPI-1:0]   ns_group1_in,
  // access qualifiers
  input  wire logic                 ns_filter_in,
  input  wire logic [SPI_IDX_W-1:0] index_in,
  // selected status word
  output logic      [WORD_W-1:0]    word_out
);

  if (NUM_SPI < 1 || NUM_SPI > MAX_SPI)
  begin : g_bad_spi_count
    $error("spi_word_select serves between 1 and 960 shared wires");
  end

  always_comb
  begin
    int k;
    k = 0;
    word_out = '0;
    for (int b = 0; b < WORD_W; b++)
    begin
      k = int'(index_in) * WORD_W + b;
      // bits past the configured count stay zero
      if (k < NUM_SPI)
      begin
        word_out[b] = level_in[k] & (~ns_filter_in | ns_group1_in[k]);
      end
    end
  end

endmodule : spi_word_select
`default_nettype wire

// [logic/irq_test_status_regs.sv]
// Notes on behaviour
// - writing one to error-test bit 0 pulses the memory-error output one cycle.
// - writing one to error-test bit 1 pulses the bus-master error output one cycle.
// - without translation support, error-test bit 1 is reserved, reads zero, ignored.
// - up to 30 wire-status registers for 960 shared interrupts, fewer if configured.
// - wire-status words or bits beyond the configured interrupts read zero, ignore writes.
// - each wire-status bit reads the current high or low level of its input.
// - first wire-status word covers inputs 32 to 63, each next word 32 more.
// - wire-status reads show live levels, untouched by pending set or clear writes.
// - with two security states, non-secure reads see only non-secure group 1 bits.
// - redistributor page holds read-only misc status at C000, private status at C080.
// - undefined redistributor test page offsets read zero and ignore writes.
// - error-test register is write-only at C004 with no defined reset value.
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module irq_test_status_regs
  import irq_test_pkg::*;
#(
  parameter int NUM_SPI     = 960,
  parameter bit HAS_LPI_ITS = 1'b1
)
(
  // clock and reset
  input  wire logic                clock_in,
  input  wire logic                rstn_in,
  // register port
  input  wire logic [ADDR_W-1:0]   addr_in,
  input  wire logic [WORD_W-1:0]   wdata_in,
  input  wire logic                wr_in,
  input  wire logic                rd_in,
  input  wire logic                ns_access_in,
  output logic      [WORD_W-1:0]   rdata_out,
  // security configuration
  input  wire logic                single_security_in,
  input  wire logic                are_ns_in,
  // shared interrupt wires and their group membership
  input  wire logic [NUM_SPI-1:0]  spi_in,
  input  wire logic [NUM_SPI-1:0]  spi_ns_group1_in,
  // private interrupt wires and core state
  input  wire logic [PPI_W-1:0]    ppi_in,
  input  wire logic [PPI_W-1:0]    ppi_ns_group1_in,
  input  wire logic                cpu_active_in,
  input  wire logic                grp0_enable_in,
  input  wire logic                grp1_ns_enable_in,
  input  wire logic                grp1_s_enable_in,
  // error outputs under test
  output logic                     ecc_fatal_out,
  output logic                     axim_err_out,
  // interrupt
  output logic                     irq_out
);

  localparam int SPI_REGS = NUM_SPI / WORD_W;
  localparam int PIN_W    = NUM_SPI + PPI_W + 1;

  if (NUM_SPI < WORD_W || NUM_SPI > MAX_SPI || (NUM_SPI % WORD_W) != 0)
  begin : g_bad_spi_count
    $error("NUM_SPI must be a multiple of 32 between 32 and 960");
  end

  // the wire-status window must offer one word for each group of 32 shared wires
  if ((int'(OFF_SPI_STATUS_LAST) - int'(OFF_SPI_STATUS_FIRST)) / 4 + 1 != MAX_SPI / WORD_W)
  begin : g_bad_spi_window
    $error("wire-status window does not match the shared wire limit");
  end

  // the private wire field must fit in one read word
  if (PPI_FIRST_BIT + PPI_W > WORD_W)
  begin : g_bad_priv_field
    $error("private wire field does not fit the read word");
  end

  // event bits must all sit inside the status and mask field
  if (EVT_ECC_BIT >= EVT_W || EVT_BUSM_BIT >= EVT_W || EVT_SPI_BIT >= EVT_W)
  begin : g_bad_evt_layout
    $error("event bit outside the status field");
  end

  // reset release
  // the block leaves reset two edges after release, never part-way through an edge
  logic rst_meta;
  logic rst_sync_n;

  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // pin synchronisation
  // enables and group bits come from same-clock logic and skip the filter
  logic [PIN_W-1:0]   pin_level;
  logic [NUM_SPI-1:0] spi_level;
  logic [PPI_W-1:0]   ppi_level;
  logic               cpu_active_level;

  pin_level_filter #(
    .W         (PIN_W)
  ) u_pin_filter (
    .clock_in  (clock_in),
    .rstn_in   (rst_sync_n),
    .pin_in    ({cpu_active_in, ppi_in, spi_in}),
    .level_out (pin_level)
  );

  assign spi_level        = pin_level[NUM_SPI-1:0];
  assign ppi_level        = pin_level[NUM_SPI+PPI_W-1:NUM_SPI];
  assign cpu_active_level = pin_level[PIN_W-1];

  // address decode
  logic                 dist_page;
  logic [OFFS_W-1:0]    offset;
  logic                 aligned;
  logic                 spi_range;
  logic [SPI_IDX_W-1:0] spi_index;
  logic                 ns_filter;
  logic                 hit_err_test;
  logic                 hit_evt_status;
  logic                 hit_evt_mask;
  logic                 hit_spi;
  logic                 hit_misc;
  logic                 hit_priv;

  // whole aligned words only, so a byte offset never aliases a register
  function automatic logic word_hit(input logic [OFFS_W-1:0] off,
                                    input logic [OFFS_W-1:0] target);
    return (off[OFFS_W-1:2] == target[OFFS_W-1:2]) && (off[1:0] == 2'h0);
  endfunction : word_hit

  always_comb
  begin
    dist_page      = ~addr_in[PAGE_BIT];
    offset         = addr_in[OFFS_W-1:0];
    aligned        = (offset[1:0] == 2'h0);
    spi_range      = (offset >= OFF_SPI_STATUS_FIRST) && (offset <= OFF_SPI_STATUS_LAST);
    spi_index      = spi_reg_index(offset);
    ns_filter      = ns_access_in & ~single_security_in;
    hit_err_test   = dist_page & word_hit(offset, OFF_ERR_TEST);
    hit_evt_status = dist_page & word_hit(offset, OFF_EVENT_STATUS);
    hit_evt_mask   = dist_page & word_hit(offset, OFF_EVENT_MASK);
    // words past the configured count have nothing behind them
    hit_spi        = dist_page & aligned & spi_range & (int'(spi_index) < SPI_REGS);
    hit_misc       = ~dist_page & word_hit(offset, OFF_MISC_STATUS);
    hit_priv       = ~dist_page & word_hit(offset, OFF_PRIV_STATUS);
  end

  // shared interrupt word
  logic [WORD_W-1:0] spi_word;

  spi_word_select #(
    .NUM_SPI      (NUM_SPI)
  ) u_spi_word (
    .level_in     (spi_level),
    .ns_group1_in (spi_ns_group1_in),
    .ns_filter_in (ns_filter),
    .index_in     (spi_index),
    .word_out     (spi_word)
  );

  // error test pulses
  logic err_test_wr;
  logic next_ecc_fatal;
  logic next_axim_err;

  always_comb
  begin
    err_test_wr    = wr_in & hit_err_test;
    // recomputed every cycle, so a single write gives a single-cycle pulse;
    // writes of one on successive cycles merge into one longer pulse
    next_ecc_fatal = err_test_wr & wdata_in[ERR_ECC_BIT];
    next_axim_err  = err_test_wr & wdata_in[ERR_BUSM_BIT] & HAS_LPI_ITS;
  end

  always_ff @(posedge clock_in or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      ecc_fatal_out <= 1'b0;
      axim_err_out  <= 1'b0;
    end
    else
    begin
      ecc_fatal_out <= next_ecc_fatal;
      axim_err_out  <= next_axim_err;
    end
  end

  // shared wire change detection
  // history resets to the filter's reset level, so release raises no false event
  logic [NUM_SPI-1:0] spi_prev;
  logic               spi_changed;

  always_comb
  begin
    spi_changed = |(spi_level ^ spi_prev);
  end

  always_ff @(posedge clock_in or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      spi_prev <= '0;
    end
    else
    begin
      spi_prev <= spi_level;
    end
  end

  // event status, mask and interrupt
  logic [EVT_W-1:0] evt_status;
  logic [EVT_W-1:0] evt_mask;
  logic [EVT_W-1:0] next_evt_status;
  logic [EVT_W-1:0] next_evt_mask;
  logic [EVT_W-1:0] evt_set;
  logic [EVT_W-1:0] evt_clear;
  logic             next_irq;

  always_comb
  begin
    evt_set               = '0;
    evt_set[EVT_ECC_BIT]  = next_ecc_fatal;
    evt_set[EVT_BUSM_BIT] = next_axim_err;
    evt_set[EVT_SPI_BIT]  = spi_changed;
    evt_clear             = '0;
    if (wr_in && hit_evt_status)
    begin
      evt_clear = wdata_in[EVT_W-1:0];
    end
    // a set in the cycle of its clear wins, so no event is lost
    next_evt_status = (evt_status & ~evt_clear) | evt_set;
    next_evt_mask   = evt_mask;
    if (wr_in && hit_evt_mask)
    begin
      next_evt_mask = wdata_in[EVT_W-1:0];
    end
    next_irq = |(next_evt_status & next_evt_mask);
  end

  always_ff @(posedge clock_in or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      evt_status <= EVT_STATUS_RST;
      evt_mask   <= EVT_MASK_RST;
      irq_out    <= 1'b0;
    end
    else
    begin
      evt_status <= next_evt_status;
      evt_mask   <= next_evt_mask;
      irq_out    <= next_irq;
    end
  end

  // redistributor page words
  // only the core pin and private wires are filtered; the enables are same-clock copies
  logic [WORD_W-1:0] misc_word;
  logic [WORD_W-1:0] priv_word;

  always_comb
  begin
    misc_word                  = '0;
    misc_word[MISC_ACTIVE_BIT] = cpu_active_level;
    if (single_security_in)
    begin
      misc_word[MISC_G1NS_BIT] = grp1_ns_enable_in;
      misc_word[MISC_G0_BIT]   = grp0_enable_in;
    end
    else if (ns_access_in)
    begin
      // non-secure view depends on the affinity routing enable
      misc_word[MISC_G1NS_BIT] = are_ns_in & grp1_ns_enable_in;
      misc_word[MISC_G0_BIT]   = ~are_ns_in & grp1_ns_enable_in;
    end
    else
    begin
      misc_word[MISC_G1S_BIT]  = grp1_s_enable_in;
      misc_word[MISC_G1NS_BIT] = grp1_ns_enable_in;
      misc_word[MISC_G0_BIT]   = grp0_enable_in;
    end
    priv_word = '0;
    priv_word[PPI_FIRST_BIT+PPI_W-1:PPI_FIRST_BIT] =
      ppi_level & (~{PPI_W{ns_filter}} | ppi_ns_group1_in);
  end

  // read data, valid only in the cycle after the read strobe
  logic [WORD_W-1:0] next_rdata;

  always_comb
  begin
    next_rdata = RDATA_RST;
    if (rd_in)
    begin
      // at most one hit is set; every other offset, the error test word too, reads zero
      if (hit_evt_status)
      begin
        next_rdata[EVT_W-1:0] = evt_status;
      end
      else if (hit_evt_mask)
      begin
        next_rdata[EVT_W-1:0] = evt_mask;
      end
      else if (hit_spi)
      begin
        next_rdata = spi_word;
      end
      else if (hit_misc)
      begin
        next_rdata = misc_word;
      end
      else if (hit_priv)
      begin
        next_rdata = priv_word;
      end
    end
  end

  always_ff @(posedge clock_in or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      rdata_out <= RDATA_RST;
    end
    else
    begin
      rdata_out <= next_rdata;
    end
  end

endmodule : irq_test_status_regs
`default_nettype wire

// [tb/irq_test_status_regs_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module irq_test_status_regs_asserts
  import irq_test_pkg::*;
#(
  parameter int NUM_SPI     = 960,
  parameter bit HAS_LPI_ITS = 1'b1
)
(
  // register port
  input wire logic              clock_in,
  input wire logic              rstn_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [WORD_W-1:0] wdata_in,
  input wire logic              wr_in,
  input wire logic              rd_in,
  input wire logic [WORD_W-1:0] rdata_out,
  // error outputs
  input wire logic              ecc_fatal_out,
  input wire logic              axim_err_out
);
  logic et;
  logic rsv;
  logic hi;
  logic e0;
  logic e1;
  assign et = !addr_in[PAGE_BIT] && addr_in[15:0] == OFF_ERR_TEST;
  assign rsv = addr_in[PAGE_BIT] && addr_in[15:0] != OFF_MISC_STATUS
    && addr_in[15:0] != OFF_PRIV_STATUS;
  // first word past the configured shared wires up to the last word slot
  assign hi = !addr_in[PAGE_BIT] && addr_in[15:0] <= OFF_SPI_STATUS_LAST
    && addr_in[15:0] >= OFF_SPI_STATUS_FIRST + 16'(NUM_SPI / 8);
  assign e0 = wr_in && et && wdata_in[0];
  assign e1 = wr_in && et && wdata_in[1];
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  ecc_pulse_a: assert property (e0 |=> ecc_fatal_out)
    else $error("memory error pulse missing");
  ecc_cause_a: assert property (ecc_fatal_out |-> $past(e0))
    else $error("memory error pulse without write");
  busm_pulse_a: assert property (e1 |=> axim_err_out == HAS_LPI_ITS)
    else $error("bus error pulse wrong");
  busm_cause_a: assert property (axim_err_out |-> HAS_LPI_ITS && $past(e1))
    else $error("bus error pulse without cause");
  quiet_write_a: assert property (wr_in && et && wdata_in[1:0] == 2'h0
    |=> !ecc_fatal_out && !axim_err_out)
    else $error("pulse on zero write");
  errtest_raz_a: assert property (rd_in && et |=> rdata_out == '0)
    else $error("error test read not zero");
  redist_rsv_a: assert property (rd_in && rsv |=> rdata_out == '0)
    else $error("reserved read not zero");
  spi_raz_a: assert property (rd_in && hi |=> rdata_out == '0)
    else $error("unimplemented word not zero");
endmodule : irq_test_status_regs_asserts
bind irq_test_status_regs irq_test_status_regs_asserts #(
  .NUM_SPI(NUM_SPI), .HAS_LPI_ITS(HAS_LPI_ITS)
) u_irq_test_status_regs_asserts (.clock_in, .rstn_in, .addr_in, .wdata_in,
  .wr_in, .rd_in, .rdata_out, .ecc_fatal_out, .axim_err_out);
`default_nettype wire

// [tb/irq_src_model.sv]
`timescale 1ns/1ps
`default_nettype none
module irq_src_model
#(
  parameter int N = 64
)
(
  // clock and wanted levels
  input  wire logic         clock_in,
  input  wire logic [N-1:0] spi_pat_in,
  input  wire logic [15:0]  ppi_pat_in,
  input  wire logic         act_in,
  // source wires
  output logic      [N-1:0] spi_out,
  output logic      [15:0]  ppi_out,
  output logic              cpu_active_out
);
  // sources are held steady levels; they move just after an edge
  always @(posedge clock_in)
  begin
    spi_out <= spi_pat_in;
    ppi_out <= ppi_pat_in;
    cpu_active_out <= act_in;
  end
endmodule : irq_src_model
`default_nettype wire

// [tb/irq_test_status_regs_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module irq_test_status_regs_tb;
  import irq_test_pkg::*;
  localparam int NS = 64;
  logic clock_in = 0, rstn_in = 0, wr_in = 0, rd_in = 0, ns_access_in = 0;
  logic single_security_in = 1, are_ns_in = 1, act = 0, g0 = 0, g1n = 0, g1s = 0;
  logic [ADDR_W-1:0] addr_in = '0;
  logic [WORD_W-1:0] wdata_in = '0, rdata_out, got;
  logic [NS-1:0] spi_pat = '0, grp1 = '0, spi_in;
  logic [15:0] ppi_pat = '0, pgrp = '0, ppi_in;
  logic cpu_active_in, ecc_fatal_out, axim_err_out, irq_out;
  logic [WORD_W-1:0] rdata_lean;
  logic ecc_lean, axim_lean;
  int fail_count = 0, compares = 0, cyc = 0;
  irq_test_status_regs #(.NUM_SPI(NS)) u_irq_test_status_regs (.clock_in, .rstn_in,
    .addr_in, .wdata_in, .wr_in, .rd_in, .ns_access_in, .rdata_out,
    .single_security_in, .are_ns_in, .spi_in, .spi_ns_group1_in(grp1), .ppi_in,
    .ppi_ns_group1_in(pgrp), .cpu_active_in, .grp0_enable_in(g0),
    .grp1_ns_enable_in(g1n), .grp1_s_enable_in(g1s), .ecc_fatal_out,
    .axim_err_out, .irq_out);
  irq_src_model #(.N(NS)) u_irq_src_model (.clock_in, .spi_pat_in(spi_pat),
    .ppi_pat_in(ppi_pat), .act_in(act), .spi_out(spi_in), .ppi_out(ppi_in),
    .cpu_active_out(cpu_active_in));
  // lean build without translation support shares every input
  irq_test_status_regs #(.NUM_SPI(NS), .HAS_LPI_ITS(1'b0)) u_irq_test_status_regs_lean (
    .clock_in, .rstn_in, .addr_in, .wdata_in, .wr_in, .rd_in, .ns_access_in,
    .rdata_out(rdata_lean), .single_security_in, .are_ns_in, .spi_in,
    .spi_ns_group1_in(grp1), .ppi_in, .ppi_ns_group1_in(pgrp), .cpu_active_in,
    .grp0_enable_in(g0), .grp1_ns_enable_in(g1n), .grp1_s_enable_in(g1s),
    .ecc_fatal_out(ecc_lean), .axim_err_out(axim_lean), .irq_out());
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task wr(input logic [16:0] a, input logic [31:0] d);
    @(posedge clock_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clock_in);
    wr_in <= 1'b0;
    #1;
  endtask : wr
  task rd(input logic [16:0] a);
    @(posedge clock_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clock_in);
    rd_in <= 1'b0;
    #1 got = rdata_out;
  endtask : rd
  task t_err;
    wr(17'h0C004, 32'h1);
    check("ecc", 32'(ecc_fatal_out), 32'h1);
    check("ecc_lean", 32'(ecc_lean), 32'h1);
    check("axim", 32'(axim_err_out), 32'h0);
    check("irq_masked", 32'(irq_out), 32'h0);
    @(posedge clock_in);
    #1 check("ecc_end", 32'(ecc_fatal_out), 32'h0);
    wr(17'h0C004, 32'h2);
    check("axim", 32'(axim_err_out), 32'h1);
    check("axim_lean", 32'(axim_lean), 32'h0);
    check("ecc", 32'(ecc_fatal_out), 32'h0);
    wr(17'h0C004, 32'hFFFF_FFFC);
    check("rsv_pulse", 32'({ecc_fatal_out, axim_err_out}), 32'h0);
    wr(17'h1C004, 32'h3);
    check("page1_pulse", 32'({ecc_fatal_out, axim_err_out}), 32'h0);
    rd(17'h0C004);
    check("err_read", got, 32'h0);
    check("err_lean", rdata_lean, 32'h0);
    rd(17'h0C010);
    check("events", got & 32'h3, 32'h3);
    wr(17'h0C014, 32'h3);
    repeat (2) @(posedge clock_in);
    #1 check("irq_on", 32'(irq_out), 32'h1);
    wr(17'h0C010, 32'h7);
    repeat (2) @(posedge clock_in);
    #1 check("irq_off", 32'(irq_out), 32'h0);
    wr(17'h0C014, 32'h1);
    wr(17'h0C004, 32'h1);
    check("irq_pulse", 32'(irq_out), 32'h1);
    wr(17'h0C010, 32'h1);
    check("irq_clear", 32'(irq_out), 32'h0);
    wr(17'h0C014, 32'h0);
  endtask : t_err
  task t_wire;
    @(posedge clock_in);
    spi_pat <= 64'hA5C3_0F81_7E24_9B16;
    grp1 <= 64'hFFFF_0000_00FF_FF00;
    ppi_pat <= 16'hC3A5;
    pgrp <= 16'h0FF0;
    act <= 1'b1;
    g0 <= 1'b1;
    g1s <= 1'b1;
    // synchroniser still holds the old level
    rd(17'h0C084);
    check("spi_sync", got, 32'h0);
    repeat (8) @(posedge clock_in);
    rd(17'h0C084);
    check("spi0", got, spi_pat[31:0]);
    rd(17'h0C088);
    check("spi1", got, spi_pat[63:32]);
    rd(17'h0C08C);
    check("spi_none", got, 32'h0);
    rd(17'h0C0F8);
    check("spi_last", got, 32'h0);
    rd(17'h1C080);
    check("ppi", got, {ppi_pat, 16'h0});
    rd(17'h1C000);
    check("misc_single", got, 32'h8000_0001);
    rd(17'h1C004);
    check("redist_rsv", got, 32'h0);
    @(posedge clock_in);
    single_security_in <= 1'b0;
    wr(17'h1C000, 32'h0);
    rd(17'h1C000);
    check("misc", got, 32'h8000_0005);
    @(posedge clock_in);
    ns_access_in <= 1'b1;
    rd(17'h0C084);
    check("spi_ns", got, spi_pat[31:0] & grp1[31:0]);
    rd(17'h0C088);
    check("spi_ns1", got, spi_pat[63:32] & grp1[63:32]);
    rd(17'h1C080);
    check("ppi_ns", got, {ppi_pat & pgrp, 16'h0});
    @(posedge clock_in);
    g1n <= 1'b1;
    rd(17'h1C000);
    check("misc_ns", got, 32'h8000_0002);
    @(posedge clock_in);
    are_ns_in <= 1'b0;
    rd(17'h1C000);
    check("misc_ns_legacy", got, 32'h8000_0001);
  endtask : t_wire
  task t_live;
    wr(17'h0C010, 32'h7);
    @(posedge clock_in);
    ns_access_in <= 1'b0;
    spi_pat <= 64'h0123_4567_89AB_CDEF;
    act <= 1'b0;
    repeat (8) @(posedge clock_in);
    rd(17'h0C084);
    check("spi_live0", got, 32'h89AB_CDEF);
    rd(17'h0C088);
    check("spi_live1", got, 32'h0123_4567);
    rd(17'h0C010);
    check("wire_event", got, 32'h0000_0004);
    rd(17'h1C000);
    check("misc_idle", got, 32'h0000_0007);
  endtask : t_live
  task summarize;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize
  initial
  begin
    forever #2 clock_in = ~clock_in;
  end
  // well past the roughly 100 cycles the scenarios need
  always @(posedge clock_in)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fail_count++;
      summarize();
    end
  end
  initial
  begin
    repeat (10) @(posedge clock_in);
    rstn_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    t_err();
    t_wire();
    t_live();
    summarize();
  end
endmodule : irq_test_status_regs_tb
`default_nettype wire
